/* hdl/pt8_timer.sv */
// Module: 8-bit period timer with prescaler, postscaler and register port
//
// Behaviour
// [R1] Readable, writable 8-bit count and period registers
// [R2] Count clock is system clock over four
// [R3] Prescale code 00:1, 01:4, 1x:16
// [R4] Count up, match period, then zero
// [R5] Matches feed 4-bit postscaler, 1 to 16
// [R6] Postscale ratio is field value plus one
// [R7] Postscaler event sets latched timer flag
// [R8] Run bit starts and stops counting
// [R9] Count/control write or reset clears scalers
// [R10] Control write leaves count unchanged
// [R11] Any reset clears the count
// [R12] Period register resets to all ones
// [R13] Control bit seven reads zero, ignored
// [R14] Period match exported for PWM time base
// [R15] Interrupt request needs flag and enable
// [R16] Software clears flag; hardware never does
`timescale 1ns/100ps
module pt8_timer
   import pt8_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Timer outputs
   output logic period_match,
   output logic period_irq
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [1:0] instr_cnt;
      logic [7:0] count;
      logic [7:0] period;
      logic [7:0] control;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] rdata;
      logic match;
      logic irq;
   } pt8_state_t;

   pt8_state_t s_q;
   pt8_state_t s_d;

   logic wr_count;
   logic wr_control;
   logic scaler_clr;
   logic instr_tick;
   logic pre_tick;
   logic hit;
   logic post_tick;
   logic [3:0] pre_last;
   logic [1:0] pre_sel;

   // ****************************************
   // Address decode
   // ****************************************
   assign wr_count = reg_wr && (reg_addr == PT8_OFF_COUNT);
   assign wr_control = reg_wr && (reg_addr == PT8_OFF_CONTROL);
   // Reset handled inside the counters by rstn
   assign scaler_clr = wr_count || wr_control;  // see [R9]
   assign pre_sel = s_q.control[PT8_CTL_PRE_MSB:PT8_CTL_PRE_LSB];

   // ****************************************
   // Prescaler selection
   // ****************************************
   always_comb begin
      case (pre_sel)  // see [R3]
         PT8_PRE_CODE_DIV1: pre_last = PT8_PRE_LAST_DIV1;
         PT8_PRE_CODE_DIV4: pre_last = PT8_PRE_LAST_DIV4;
         default: pre_last = PT8_PRE_LAST_DIV16;
      endcase
   end

   // Instruction clock tick, one in four system cycles
   assign instr_tick = s_q.control[PT8_CTL_RUN_BIT]
      && (s_q.instr_cnt == PT8_INSTR_DIV_LAST);  // see [R2] see [R8]

   pt8_div_cnt #(
      .W(4)
   ) u_pre (
      .clk(clk),
      .rstn(rstn),
      .clr(scaler_clr),
      .step(instr_tick),
      .last(pre_last),
      .wrap(pre_tick)
   );

   // Count reaching period on an increment cycle
   assign hit = pre_tick && (s_q.count == s_q.period) && !wr_count;  // see [R4]

   pt8_div_cnt #(
      .W(4)
   ) u_post (
      .clk(clk),
      .rstn(rstn),
      .clr(scaler_clr),
      .step(hit),
      .last(s_q.control[PT8_CTL_POST_MSB:PT8_CTL_POST_LSB]),
      .wrap(post_tick)
   );  // see [R5] see [R6]

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      // Free-running phase keeps the instruction clock steady across stops
      s_d.instr_cnt = s_q.instr_cnt + 2'h1;
      if (wr_count) begin
         s_d.count = reg_wdata;  // see [R1]
      end else if (hit) begin
         s_d.count = PT8_COUNT_RST;  // see [R4]
      end else if (pre_tick) begin
         s_d.count = s_q.count + 8'h01;  // see [R4]
      end
      // Control write sets control and clears the scalers, count kept
      if (wr_control) begin
         s_d.control = reg_wdata & PT8_CTL_MASK;  // see [R10] see [R13]
      end
      if (reg_wr && reg_addr == PT8_OFF_PERIOD) begin
         s_d.period = reg_wdata;  // see [R1]
      end
      if (reg_wr && reg_addr == PT8_OFF_IRQ_ENABLES) begin
         s_d.enables = reg_wdata;
      end
      if (reg_wr && reg_addr == PT8_OFF_IRQ_FLAGS) begin
         s_d.flags = reg_wdata;  // see [R16]
      end
      // Set wins over a simultaneous software clear
      if (post_tick) begin
         s_d.flags[PT8_IRQ_BIT] = 1'b1;  // see [R7]
      end
      s_d.match = hit;  // see [R14]
      s_d.irq = s_d.flags[PT8_IRQ_BIT] && s_d.enables[PT8_IRQ_BIT];  // see [R15]
      s_d.rdata = PT8_REG_RST;
      if (reg_rd) begin
         case (reg_addr)
            PT8_OFF_COUNT: s_d.rdata = s_q.count;
            PT8_OFF_PERIOD: s_d.rdata = s_q.period;
            PT8_OFF_CONTROL: s_d.rdata = s_q.control;
            PT8_OFF_IRQ_FLAGS: s_d.rdata = s_q.flags;
            PT8_OFF_IRQ_ENABLES: s_d.rdata = s_q.enables;
            default: s_d.rdata = PT8_REG_RST;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q.instr_cnt <= '0;
         s_q.count <= PT8_COUNT_RST;  // see [R11]
         s_q.period <= PT8_PERIOD_RST;  // see [R12]
         s_q.control <= PT8_REG_RST;
         s_q.flags <= PT8_REG_RST;
         s_q.enables <= PT8_REG_RST;
         s_q.rdata <= PT8_REG_RST;
         s_q.match <= 1'b0;
         s_q.irq <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign period_match = s_q.match;
   assign period_irq = s_q.irq;

endmodule

/* hdl/pt8_pkg.sv */
// Package: register map, field layout and reset values of the period timer
package pt8_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] PT8_OFF_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] PT8_OFF_COUNT = 8'h11;
   localparam logic [7:0] PT8_OFF_CONTROL = 8'h12;
   localparam logic [7:0] PT8_OFF_IRQ_ENABLES = 8'h8C;
   localparam logic [7:0] PT8_OFF_PERIOD = 8'h92;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PT8_CTL_PRE_LSB = 0;
   localparam int PT8_CTL_PRE_MSB = 1;
   localparam int PT8_CTL_RUN_BIT = 2;
   localparam int PT8_CTL_POST_LSB = 3;
   localparam int PT8_CTL_POST_MSB = 6;
   localparam int PT8_IRQ_BIT = 1;
   localparam logic [7:0] PT8_CTL_MASK = 8'h7F;

   // ****************************************
   // Reset values and scaling constants
   // ****************************************
   localparam logic [7:0] PT8_COUNT_RST = 8'h00;
   localparam logic [7:0] PT8_PERIOD_RST = 8'hFF;
   localparam logic [7:0] PT8_REG_RST = 8'h00;
   localparam logic [1:0] PT8_INSTR_DIV_LAST = 2'h3;
   localparam logic [3:0] PT8_PRE_LAST_DIV1 = 4'h0;
   localparam logic [3:0] PT8_PRE_LAST_DIV4 = 4'h3;
   localparam logic [3:0] PT8_PRE_LAST_DIV16 = 4'hF;
   localparam logic [1:0] PT8_PRE_CODE_DIV1 = 2'h0;
   localparam logic [1:0] PT8_PRE_CODE_DIV4 = 2'h1;

endpackage

/* hdl/pt8_div_cnt.sv */
// Module: clearable wrap-around divide counter
`timescale 1ns/100ps
module pt8_div_cnt
   import pt8_pkg::*;
#(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Control
   input wire logic clr,
   input wire logic step,
   input wire logic [W-1:0] last,
   // Result
   output logic wrap
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [W-1:0] cnt;
   } pt8_div_state_t;

   pt8_div_state_t s_q;
   pt8_div_state_t s_d;

   always_comb begin
      s_d = s_q;
      wrap = step && (s_q.cnt >= last);
      if (clr) begin
         s_d.cnt = '0;
      end else if (wrap) begin
         s_d.cnt = '0;
      end else if (step) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

/* dv/pt8_timer_sva.sv */
// Checker: port-level properties of the period timer
`timescale 1ns/100ps
module pt8_timer_sva
   import pt8_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port and outputs
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic period_match,
   input wire logic period_irq
);
   // ***************
   // Properties
   // ***************
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire wr_fe = reg_wr && (reg_addr == PT8_OFF_IRQ_FLAGS || reg_addr == PT8_OFF_IRQ_ENABLES);
   sequence s_prd_rw;
      reg_wr && reg_addr == PT8_OFF_PERIOD ##1 reg_rd && reg_addr == PT8_OFF_PERIOD;
   endsequence
   sequence s_stop;
      reg_wr && reg_addr == PT8_OFF_CONTROL && !reg_wdata[PT8_CTL_RUN_BIT];
   endsequence
   chk_rdata_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero when idle");
   chk_period_rw: assert property (
      s_prd_rw |=> reg_rdata == $past(reg_wdata, 2)) else $error("period readback wrong");
   chk_ctl_msb: assert property (
      reg_rd && reg_addr == PT8_OFF_CONTROL |=> !reg_rdata[7]) else $error("control bit7 set");
   chk_match_gap: assert property (
      period_match |=> !period_match [*3]) else $error("matches too close");
   chk_stop_run: assert property (
      s_stop |=> ##2 !period_match [*8]) else $error("match while stopped");
   // No match one cycle on means no set raced the clear
   chk_flag_clr: assert property (
      reg_wr && reg_addr == PT8_OFF_IRQ_FLAGS && !reg_wdata[PT8_IRQ_BIT] ##1 !period_match
      |-> !period_irq) else $error("request after flag clear");
   chk_en_clr: assert property (
      reg_wr && reg_addr == PT8_OFF_IRQ_ENABLES && !reg_wdata[PT8_IRQ_BIT] |=> !period_irq)
      else $error("request while disabled");
   chk_flag_sticky: assert property (
      !wr_fe ##1 period_irq && !wr_fe |=> period_irq) else $error("flag dropped by itself");
endmodule
bind pt8_timer pt8_timer_sva pt8_timer_sva_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .period_match, .period_irq);

/* dv/pt8_timer_tb_top.sv */
// Testbench: register, scaling and flag checks of the period timer
`timescale 1ns/100ps
module pt8_timer_tb_top import pt8_pkg::*;;
   // ***************
   // Stimulus and scoreboard
   // ***************
   logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rd_d = 0, period_match, period_irq;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'hAE57;
   logic [7:0] ra[6] = '{PT8_OFF_IRQ_FLAGS, PT8_OFF_COUNT, PT8_OFF_CONTROL, PT8_OFF_IRQ_ENABLES,
      PT8_OFF_PERIOD, 8'h55};
   logic [7:0] re[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
   logic [3:0] post[3] = '{4'h0, 4'h3, 4'hF};
   int error_cnt = 0, checks_done = 0, cyc = 0, n, k;
   pt8_timer pt8_timer_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .period_match, .period_irq);
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] xs(logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Strobes stay up between back-to-back calls; idle drops them
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      exp_q.push_back(e);
      @(posedge clk);
   endtask
   task automatic idle(int c);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (c) @(posedge clk);
   endtask
   task automatic wait_match();
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (period_match !== 1'b1 && n < 2000);
      chk("match wait", 16'h1, 16'(period_match === 1'b1));
   endtask
   always @(posedge clk) begin
      if (rd_d) chk("read data", 16'(exp_q.pop_front()), 16'(reg_rdata));
      rd_d <= reg_rd;
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      foreach (ra[i]) rd(ra[i], re[i]);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         v = seed[7:0];
         wr(PT8_OFF_PERIOD, v);
         rd(PT8_OFF_PERIOD, v);
         wr(PT8_OFF_IRQ_FLAGS, v);
         rd(PT8_OFF_IRQ_FLAGS, v);
      end
      wr(PT8_OFF_COUNT, v);
      wr(PT8_OFF_CONTROL, 8'hFB);
      idle(40);
      rd(PT8_OFF_CONTROL, 8'h7B);
      rd(PT8_OFF_COUNT, v);
      wr(PT8_OFF_PERIOD, 8'h02);
      for (int c = 0; c < 4; c++) begin
         wr(PT8_OFF_CONTROL, 8'(4 + c));
         idle(1);
         wait_match();
         wait_match();
         chk("match gap", 16'(12 * (c == 0 ? 1 : c == 1 ? 4 : 16)), 16'(n));
      end
      // Clears every 40 cycles starve a 64-cycle prescaler
      wr(PT8_OFF_CONTROL, 8'h06);
      wr(PT8_OFF_PERIOD, 8'h00);
      wr(PT8_OFF_COUNT, 8'h00);
      n = 0;
      for (k = 0; k < 400; k++) begin
         if (k % 80 == 0) wr(PT8_OFF_COUNT, 8'h00);
         else if (k % 80 == 40) wr(PT8_OFF_CONTROL, 8'h06);
         else idle(1);
         if (period_match === 1'b1) n++;
      end
      chk("scaler clear", 16'h0, 16'(n));
      wr(PT8_OFF_PERIOD, 8'h02);
      foreach (post[i]) begin
         wr(PT8_OFF_CONTROL, 8'h00);
         idle(12);
         wr(PT8_OFF_IRQ_ENABLES, 8'h02);
         wr(PT8_OFF_IRQ_FLAGS, 8'h00);
         wr(PT8_OFF_CONTROL, {1'b0, post[i], 3'h4});
         idle(1);
         n = 0;
         for (k = 0; k < 3000 && period_irq !== 1'b1; k++) begin
            @(posedge clk);
            if (period_match === 1'b1) n++;
         end
         chk("postscale", 16'(post[i]) + 16'h1, 16'(n));
      end
      wr(PT8_OFF_CONTROL, 8'h00);
      idle(12);
      rd(PT8_OFF_IRQ_FLAGS, 8'h02);
      wr(PT8_OFF_IRQ_ENABLES, 8'h00);
      idle(3);
      chk("irq masked", 16'h0, 16'(period_irq));
      wr(PT8_OFF_IRQ_ENABLES, 8'h02);
      wr(PT8_OFF_IRQ_FLAGS, 8'h00);
      rd(PT8_OFF_IRQ_FLAGS, 8'h00);
      idle(3);
      chk("irq cleared", 16'h0, 16'(period_irq));
      // Reset with the timer stopped must restore count and period
      wr(PT8_OFF_COUNT, 8'h5A);
      wr(PT8_OFF_PERIOD, 8'h33);
      rd(PT8_OFF_COUNT, 8'h5A);
      idle(2);
      rstn <= 1'b0;
      idle(3);
      rstn <= 1'b1;
      rd(PT8_OFF_COUNT, PT8_COUNT_RST);
      rd(PT8_OFF_PERIOD, PT8_PERIOD_RST);
      idle(3);
      print_verdict();
   end
endmodule
